// ---- core/adcc_pkg.sv ----
package adcc_pkg;

  // register byte offsets
  localparam logic [7:0] ADCC_OFF_CTRL0 = 8'h00;
  localparam logic [7:0] ADCC_OFF_CTRL1 = 8'h04;
  localparam logic [7:0] ADCC_OFF_PINSEL = 8'h08;
  localparam logic [7:0] ADCC_OFF_RESULT = 8'h0c;
  localparam logic [7:0] ADCC_OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADCC_OFF_IRQ_MASK = 8'h14;

  // conv_control_0 fields
  localparam int ADCC_C0_START = 7;
  localparam int ADCC_C0_PEND = 6;
  localparam int ADCC_C0_PWR_OFF = 5;
  localparam int ADCC_C0_ALIGN = 4;
  localparam int ADCC_C0_CH_LO = 0;
  // conv_control_1 fields
  localparam int ADCC_C1_INT_REF = 7;
  localparam int ADCC_C1_BANDGAP_EN = 6;
  localparam int ADCC_C1_REF_SEL = 4;
  localparam int ADCC_C1_DIV_LO = 0;
  // interrupt status bit
  localparam int ADCC_IRQ_DONE = 0;

  // reset values
  localparam logic ADCC_RST_PEND = 1'b1;
  localparam logic ADCC_RST_PWR_OFF = 1'b1;
  localparam logic [3:0] ADCC_RST_PINSEL = 4'hf;

  // conversion length in conversion clock periods
  localparam logic [3:0] ADCC_CONV_LAST = 4'hf;
  localparam int ADCC_CONV_PERIODS = 16;

  localparam logic [1:0] ADCC_RESP_OKAY = 2'h0;
  localparam logic [1:0] ADCC_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ADCC_ST_IDLE = 2'b00,
    ADCC_ST_HOLD = 2'b01,
    ADCC_ST_CONV = 2'b10
  } adcc_state_type;

  // controls towards the analog converter core
  typedef struct packed {
    logic power_down;
    logic core_reset;
    logic conv_clk_en;
    logic [2:0] input_sel;
    logic bandgap_en;
    logic ref_ext;
  } adcc_core_ctl_type;

endpackage : adcc_pkg

// ---- core/adcc_top.sv ----
// Contract
// R1: pin-select low bits make port A pins analog
// R2: pin-select upper four bits read zero
// R3: conversion starts after start goes high then low
// R4: start high holds converter reset, pending set
// R5: hardware clears pending flag on completion
// R6: completion sets interrupt flag, raises enabled interrupt
// R7: software may poll pending flag instead
// R8: three-bit code divides system clock by 1..64; code 111 divides by 128
// R9: software keeps conversion clock 0.5 to 10 us
// R10: at 4 MHz avoid codes 000, 110
// R11: power-off bit one powers converter down
// R12: software waits settling after power on
// R13: software powers converter off when unused
// R14: reference select picks supply or external pin
// R15: channel field or internal reference drives input
// R16: alignment bit justifies result left or right
// R17: conversion lasts sixteen conversion clock periods
// R18: result updates when pending flag clears
module adcc_top
  import adcc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [11:0] core_data,
  output adcc_core_ctl_type core_ctl,
  output logic [3:0] analog_pin_en,
  output logic vref_pin_sel,
  output logic irq
);

  function automatic logic [6:0] div_mask(input logic [2:0] code);
    // 111 runs as divide by 128
    div_mask = 7'((8'h01 << code) - 8'h01);
  endfunction : div_mask

  function automatic logic [15:0] align_result(input logic [11:0] res, input logic right);
    align_result = right ? {4'h0, res} : {res, 4'h0};
  endfunction : align_result

  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr == ADCC_OFF_CTRL0) || (addr == ADCC_OFF_CTRL1) || (addr == ADCC_OFF_PINSEL) ||
                (addr == ADCC_OFF_RESULT) || (addr == ADCC_OFF_IRQ_STAT) || (addr == ADCC_OFF_IRQ_MASK);
  endfunction : is_mapped

  // bus state
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic aw_held_ff, w_held_ff;
  logic [7:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;

  // control registers
  logic start_ff, pend_ff, pwr_off_ff, align_ff;
  logic [1:0] chan_ff;
  logic int_ref_ff, bandgap_ff, ref_sel_ff;
  logic [2:0] div_sel_ff;
  logic [3:0] pinsel_ff;
  logic irq_stat_ff, irq_mask_ff, irq_ff;
  logic [11:0] result_ff;

  // conversion engine
  adcc_state_type state_ff, nxt_state;
  logic [6:0] presc_ff;
  logic [3:0] bitcnt_ff;
  adcc_core_ctl_type core_ctl_ff, nxt_core_ctl;

  // write path decode
  wire aw_take = s_axi_awvalid && awready_ff;
  wire w_take = s_axi_wvalid && wready_ff;
  wire wr_go = aw_held_ff && w_held_ff && !bvalid_ff;
  wire wr_lane0 = wr_go && w_strb_ff[0];
  wire wr_ctrl0 = wr_lane0 && (aw_addr_ff == ADCC_OFF_CTRL0);
  wire wr_ctrl1 = wr_lane0 && (aw_addr_ff == ADCC_OFF_CTRL1);
  wire wr_pinsel = wr_lane0 && (aw_addr_ff == ADCC_OFF_PINSEL);
  wire wr_stat = wr_lane0 && (aw_addr_ff == ADCC_OFF_IRQ_STAT);
  wire wr_mask = wr_lane0 && (aw_addr_ff == ADCC_OFF_IRQ_MASK);
  wire nxt_aw_held = aw_held_ff ? !wr_go : aw_take;
  wire nxt_w_held = w_held_ff ? !wr_go : w_take;
  wire nxt_bvalid = bvalid_ff ? !s_axi_bready : wr_go;
  wire [1:0] wr_resp = is_mapped(aw_addr_ff) ? ADCC_RESP_OKAY : ADCC_RESP_SLVERR;

  // read path decode
  wire ar_take = s_axi_arvalid && arready_ff;
  wire nxt_rvalid = rvalid_ff ? !s_axi_rready : ar_take;
  wire [7:0] ctrl0_rd = {start_ff, pend_ff, pwr_off_ff, align_ff, 2'h0, chan_ff};
  wire [7:0] ctrl1_rd = {int_ref_ff, bandgap_ff, 1'b0, ref_sel_ff, 1'b0, div_sel_ff};
  wire [31:0] rd_word =
    (s_axi_araddr == ADCC_OFF_CTRL0) ? {24'h0, ctrl0_rd} :
    (s_axi_araddr == ADCC_OFF_CTRL1) ? {24'h0, ctrl1_rd} :
    (s_axi_araddr == ADCC_OFF_PINSEL) ? {28'h0, pinsel_ff} : // R2
    (s_axi_araddr == ADCC_OFF_RESULT) ? {16'h0, align_result(result_ff, align_ff)} : // R16
    (s_axi_araddr == ADCC_OFF_IRQ_STAT) ? {31'h0, irq_stat_ff} :
    (s_axi_araddr == ADCC_OFF_IRQ_MASK) ? {31'h0, irq_mask_ff} : 32'h0;
  wire [1:0] rd_resp = is_mapped(s_axi_araddr) ? ADCC_RESP_OKAY : ADCC_RESP_SLVERR;

  // conversion clock divider and sequencing
  wire in_conv = (state_ff == ADCC_ST_CONV);
  wire tick = in_conv && (presc_ff == div_mask(div_sel_ff)); // R8
  wire conv_done = tick && (bitcnt_ff == ADCC_CONV_LAST); // R17
  wire nxt_pend = start_ff ? 1'b1 : (conv_done ? 1'b0 : pend_ff); // R4 R5
  wire nxt_irq_stat = conv_done || (irq_stat_ff && !(wr_stat && w_data_ff[ADCC_IRQ_DONE])); // R6
  wire nxt_irq_mask = wr_mask ? w_data_ff[ADCC_IRQ_DONE] : irq_mask_ff;

  always_comb begin
    case (state_ff)
      ADCC_ST_IDLE: nxt_state = start_ff ? ADCC_ST_HOLD : ADCC_ST_IDLE;
      ADCC_ST_HOLD: nxt_state = start_ff ? ADCC_ST_HOLD : ADCC_ST_CONV; // R3
      ADCC_ST_CONV: nxt_state = start_ff ? ADCC_ST_HOLD : (conv_done ? ADCC_ST_IDLE : ADCC_ST_CONV);
      default: nxt_state = ADCC_ST_IDLE;
    endcase
  end

  always_comb begin
    nxt_core_ctl.power_down = pwr_off_ff; // R11
    nxt_core_ctl.core_reset = start_ff; // R4
    nxt_core_ctl.conv_clk_en = tick;
    nxt_core_ctl.input_sel = int_ref_ff ? 3'h4 : {1'b0, chan_ff}; // R15
    nxt_core_ctl.bandgap_en = bandgap_ff;
    nxt_core_ctl.ref_ext = ref_sel_ff; // R14
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      bresp_ff <= ADCC_RESP_OKAY;
    end else begin
      aw_held_ff <= nxt_aw_held;
      w_held_ff <= nxt_w_held;
      bvalid_ff <= nxt_bvalid;
      awready_ff <= !nxt_aw_held && !nxt_bvalid;
      wready_ff <= !nxt_w_held && !nxt_bvalid;
      if (wr_go) bresp_ff <= wr_resp;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_ff <= 8'h00;
      w_data_ff <= 32'h0;
      w_strb_ff <= 4'h0;
    end else begin
      if (aw_take) aw_addr_ff <= s_axi_awaddr;
      if (w_take) w_data_ff <= s_axi_wdata;
      if (w_take) w_strb_ff <= s_axi_wstrb;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= ADCC_RESP_OKAY;
    end else begin
      rvalid_ff <= nxt_rvalid;
      arready_ff <= !nxt_rvalid;
      if (ar_take) rdata_ff <= rd_word;
      if (ar_take) rresp_ff <= rd_resp;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_ff <= 1'b0;
      pwr_off_ff <= ADCC_RST_PWR_OFF;
      align_ff <= 1'b0;
      chan_ff <= 2'h0;
    end else if (wr_ctrl0) begin
      start_ff <= w_data_ff[ADCC_C0_START];
      pwr_off_ff <= w_data_ff[ADCC_C0_PWR_OFF];
      align_ff <= w_data_ff[ADCC_C0_ALIGN];
      chan_ff <= w_data_ff[ADCC_C0_CH_LO +: 2];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_ref_ff <= 1'b0;
      bandgap_ff <= 1'b0;
      ref_sel_ff <= 1'b0;
      div_sel_ff <= 3'h0;
    end else if (wr_ctrl1) begin
      int_ref_ff <= w_data_ff[ADCC_C1_INT_REF];
      bandgap_ff <= w_data_ff[ADCC_C1_BANDGAP_EN];
      ref_sel_ff <= w_data_ff[ADCC_C1_REF_SEL];
      div_sel_ff <= w_data_ff[ADCC_C1_DIV_LO +: 3];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pinsel_ff <= ADCC_RST_PINSEL;
    end else if (wr_pinsel) begin
      pinsel_ff <= w_data_ff[3:0]; // R1
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= ADCC_ST_IDLE;
      presc_ff <= 7'h00;
      bitcnt_ff <= 4'h0;
      pend_ff <= ADCC_RST_PEND;
      result_ff <= 12'h000;
    end else begin
      state_ff <= nxt_state;
      presc_ff <= (!in_conv || tick) ? 7'h00 : presc_ff + 7'h01;
      bitcnt_ff <= !in_conv ? 4'h0 : (tick ? bitcnt_ff + 4'h1 : bitcnt_ff);
      pend_ff <= nxt_pend;
      if (conv_done) result_ff <= core_data; // R18
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_ff <= 1'b0;
      irq_mask_ff <= 1'b0;
      irq_ff <= 1'b0;
      core_ctl_ff <= '{power_down: 1'b1, core_reset: 1'b0, conv_clk_en: 1'b0, input_sel: 3'h0,
                       bandgap_en: 1'b0, ref_ext: 1'b0};
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= nxt_irq_mask;
      irq_ff <= nxt_irq_stat && nxt_irq_mask; // R6
      core_ctl_ff <= nxt_core_ctl;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign core_ctl = core_ctl_ff;
  assign analog_pin_en = pinsel_ff;
  assign vref_pin_sel = ref_sel_ff;
  assign irq = irq_ff;

  // helper: cycles spent converting
  logic [12:0] conv_cyc_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) conv_cyc_ff <= 13'h0;
    else conv_cyc_ff <= in_conv ? conv_cyc_ff + 13'h1 : 13'h0;
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_start_pulse;
    start_ff ##1 !start_ff;
  endsequence

  sequence s_conv_entry;
    (state_ff == ADCC_ST_HOLD) ##1 (state_ff == ADCC_ST_CONV);
  endsequence

  sequence s_stat_clear;
    irq_stat_ff && wr_stat && w_data_ff[ADCC_IRQ_DONE];
  endsequence

  a_pin_select_out: assert property (wr_pinsel |=> analog_pin_en == w_data_ff[3:0]) // R1
    else $error("analog pin enables differ from pin-select write");
  a_pinsel_kept: assert property (!wr_pinsel |=> $stable(analog_pin_en)) // R1
    else $error("analog pin enables changed without a write");
  a_pinsel_upper_zero: assert property (ar_take && s_axi_araddr == ADCC_OFF_PINSEL // R2
    |=> s_axi_rdata[31:4] == 28'h0)
    else $error("pin-select upper bits not zero");
  a_start_needs_fall: assert property ($rose(in_conv) |-> $past(start_ff, 2) && !$past(start_ff)) // R3
    else $error("conversion began without start high then low");
  a_hold_state: assert property (start_ff |=> state_ff == ADCC_ST_HOLD) // R3
    else $error("start high did not hold the sequencer");
  a_start_holds_reset: assert property (s_start_pulse |-> pend_ff && core_ctl.core_reset) // R4
    else $error("start high did not reset converter and set pending");
  a_pend_forced: assert property (start_ff |=> pend_ff && core_ctl.core_reset) // R4
    else $error("pending not forced while start high");
  a_done_clears_pend: assert property (conv_done && !start_ff |=> !pend_ff && state_ff == ADCC_ST_IDLE) // R5
    else $error("pending not cleared at end of conversion");
  a_busy_pending: assert property (in_conv |-> pend_ff) // R5
    else $error("pending low while converting");
  a_done_sets_irq: assert property (conv_done ##1 irq_mask_ff |-> irq_stat_ff ##1 irq) // R6
    else $error("completion did not raise interrupt");
  a_stat_clear_ok: assert property (s_stat_clear ##0 !conv_done |=> !irq_stat_ff) // R6
    else $error("write one did not clear done status");
  a_stat_set_wins: assert property (s_stat_clear ##0 conv_done |=> irq_stat_ff) // R6
    else $error("clear beat a completion in the same cycle");
  a_irq_masked: assert property (!irq_mask_ff && !wr_mask |=> !irq) // R6
    else $error("masked interrupt raised");
  a_irq_raise: assert property (irq_stat_ff && irq_mask_ff && !wr_stat && !wr_mask |=> irq) // R6
    else $error("unmasked status did not raise interrupt");
  a_mask_write: assert property (wr_mask |=> irq_mask_ff == w_data_ff[ADCC_IRQ_DONE]) // R6
    else $error("mask write not taken");
  a_divider_tick: assert property (in_conv && div_sel_ff == 3'h3 && $stable(div_sel_ff) && tick // R8
    |=> !tick[*7] ##1 (tick || !in_conv || start_ff))
    else $error("divide by 8 tick spacing wrong");
  a_divider_one: assert property (s_conv_entry ##0 (div_sel_ff == 3'h0) |-> tick) // R8
    else $error("divide by 1 gave no tick");
  a_clk_en_follow: assert property (##1 core_ctl.conv_clk_en == $past(tick)) // R8
    else $error("conversion clock enable not one pulse per tick");
  a_power_follow: assert property (##1 core_ctl.power_down == $past(pwr_off_ff)) // R11
    else $error("power-down output does not follow power-off bit");
  a_ref_select: assert property (vref_pin_sel == ref_sel_ff && core_ctl.ref_ext == $past(ref_sel_ff)) // R14
    else $error("reference select not driven");
  a_ext_ref_pin: assert property (wr_ctrl1 |=> vref_pin_sel == w_data_ff[ADCC_C1_REF_SEL]) // R14
    else $error("reference pin select not written");
  a_input_route: assert property (int_ref_ff |=> core_ctl.input_sel == 3'h4) // R15
    else $error("internal reference not routed");
  a_result_align: assert property (ar_take && s_axi_araddr == ADCC_OFF_RESULT && !align_ff // R16
    |=> s_axi_rdata[3:0] == 4'h0 && s_axi_rdata[31:16] == 16'h0)
    else $error("left-justified result misplaced");
  a_conv_length: assert property (s_conv_entry ##0 (div_sel_ff == 3'h0) ##1 (in_conv && !conv_done)[*8] // R17
    ##1 (in_conv && !conv_done)[*6] |=> conv_done || !in_conv)
    else $error("divide by 1 conversion not sixteen cycles");
  a_conv_len_any: assert property (conv_done && !start_ff && !$past(start_ff) // R17
    |-> conv_cyc_ff + 13'h1 == 13'(ADCC_CONV_PERIODS * (int'(div_mask(div_sel_ff)) + 1))
      || !$stable(div_sel_ff))
    else $error("conversion length not sixteen conversion clocks");
  a_result_update: assert property (conv_done && !start_ff |=> result_ff == $past(core_data) && !pend_ff) // R18
    else $error("result not loaded as pending clears");

endmodule : adcc_top

// ---- dv/adcc_core_model.sv ----
module adcc_core_model
  import adcc_pkg::*;
(
  input wire adcc_core_ctl_type core_ctl,
  output logic [11:0] core_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] level;
  // value names the routed input and the reference in use
  assign level = {1'b0, core_ctl.input_sel, 8'ha5} ^ {11'h0, core_ctl.ref_ext};
  // a powered-down core shows nothing usable
  assign core_data = core_ctl.power_down ? ~level : level;
endmodule : adcc_core_model

// ---- dv/adcc_top_tb.sv ----
module adcc_top_tb
  import adcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, vref_pin_sel, irq;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rd;
  logic [11:0] core_data;
  logic [3:0] analog_pin_en;
  adcc_core_ctl_type core_ctl;
  int errors = 0;
  int checked = 0;

  always #2 aclk = ~aclk;

  adcc_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .core_data(core_data),
    .core_ctl(core_ctl), .analog_pin_en(analog_pin_en), .vref_pin_sel(vref_pin_sel), .irq(irq));

  adcc_core_model core_u (.core_ctl(core_ctl), .core_data(core_data));

  task report_and_stop;
    if (errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task hang;
    errors++;
    report_and_stop();
  endtask : hang

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic aw_left, w_left;
    n = 0;
    aw_left = 1'b1;
    w_left = 1'b1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw_left || w_left) begin
      @(posedge aclk);
      if (aw_left && awready) begin
        awvalid <= 1'b0;
        aw_left = 1'b0;
      end
      if (w_left && wready) begin
        wvalid <= 1'b0;
        w_left = 1'b0;
      end
      n++;
      if (n > 100) hang();
    end
    while (bvalid !== 1'b1) begin
      @(posedge aclk);
      n++;
      if (n > 200) hang();
    end
    rs = bresp;
    bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (n > 100) hang();
    end while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) begin
      @(posedge aclk);
      n++;
      if (n > 200) hang();
    end
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : axr

  task automatic conv(input int code, input logic use_irq);
    logic [1:0] ch;
    logic al, ir, rf;
    logic [2:0] sel;
    logic [11:0] res;
    int n;
    ch = code[1:0];
    al = code[0];
    rf = code[1];
    ir = (code == 7);
    sel = ir ? 3'h4 : {1'b0, ch};
    res = {1'b0, sel, 8'ha5} ^ {11'h0, rf};
    axw(ADCC_OFF_CTRL1, {24'h0, ir, ir, 1'b0, rf, 1'b0, code[2:0]});
    chk(vref_pin_sel, rf);
    // core controls land one cycle after the register
    @(posedge aclk);
    chk(core_ctl.ref_ext, rf);
    chk(core_ctl.bandgap_en, ir);
    axw(ADCC_OFF_CTRL0, {24'h0, 1'b1, 2'h0, al, 2'h0, ch});
    repeat (40) @(posedge aclk);
    axr(ADCC_OFF_CTRL0);
    chk(rd, {24'h0, 2'h3, 1'b0, al, 2'h0, ch});
    chk(core_ctl.core_reset, 1'b1);
    chk(core_ctl.input_sel, sel);
    axw(ADCC_OFF_CTRL0, {24'h0, 3'h0, al, 2'h0, ch});
    n = 0;
    if (use_irq) begin
      while (irq !== 1'b1) begin
        @(posedge aclk);
        n++;
        if (n > 3000) hang();
      end
      chk(n >= (16 << code) && n <= (16 << code) + 4, 1'b1);
      axr(ADCC_OFF_CTRL0);
    end else begin
      do begin
        axr(ADCC_OFF_CTRL0);
        n++;
        if (n > 1000) hang();
      end while (rd[ADCC_C0_PEND] !== 1'b0);
      chk(irq, 1'b0);
    end
    chk(rd[ADCC_C0_PEND], 1'b0);
    axr(ADCC_OFF_RESULT);
    chk(rd, al ? {20'h0, res} : {16'h0, res, 4'h0});
    axr(ADCC_OFF_IRQ_STAT);
    chk(rd, 32'h1);
    axw(ADCC_OFF_IRQ_STAT, 32'h1);
    axr(ADCC_OFF_IRQ_STAT);
    chk(rd, 32'h0);
    chk(irq, 1'b0);
  endtask : conv

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    axr(ADCC_OFF_CTRL0);
    chk(rd, 32'h60);
    chk(core_ctl.power_down, 1'b1);
    axr(ADCC_OFF_PINSEL);
    chk(rd, 32'hf);
    chk(analog_pin_en, 4'hf);
    axw(ADCC_OFF_PINSEL, 32'ha5);
    chk(rs, ADCC_RESP_OKAY);
    axr(ADCC_OFF_PINSEL);
    chk(rd, 32'h5);
    chk(analog_pin_en, 4'h5);
    axw(8'h40, 32'h1);
    chk(rs, ADCC_RESP_SLVERR);
    axr(8'h40);
    chk(rs, ADCC_RESP_SLVERR);
    chk(rd, 32'h0);
    // lane 0 disabled: write must have no effect
    wstrb <= 4'he;
    axw(ADCC_OFF_PINSEL, 32'h3);
    wstrb <= 4'hf;
    axr(ADCC_OFF_PINSEL);
    chk(rd, 32'h5);
    axw(ADCC_OFF_IRQ_MASK, 32'h1);
    axw(ADCC_OFF_CTRL0, 32'h0);
    @(posedge aclk);
    chk(core_ctl.power_down, 1'b0);
    // settling time after power-up
    repeat (50) @(posedge aclk);
    for (int code = 0; code < 8; code++) conv(code, 1'b1);
    axw(ADCC_OFF_IRQ_MASK, 32'h0);
    // only the slowest divider keeps the conversion clock period inside 0.5 to 10 us here
    conv(7, 1'b0);
    axw(ADCC_OFF_CTRL0, 32'h20);
    @(posedge aclk);
    chk(core_ctl.power_down, 1'b1);
    report_and_stop();
  end
endmodule : adcc_top_tb
